// ===== verilog/tcs_pkg.sv
// timer clock select: shared constants, register map, field layout
// assumes a 20-bit byte address, 16-bit register port, one 250 MHz clock
`default_nettype none
package tcs_pkg;
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int PRESC_W = 16;
  localparam int CLK_PERIOD_NS = 4;

  localparam logic [19:0] ADDR_MODE_BASE = 20'hf0190;
  localparam logic [19:0] ADDR_MODE_LAST = 20'hf019e;
  localparam logic [19:0] ADDR_RUN_STATUS = 20'hf01b0;
  localparam logic [19:0] ADDR_START = 20'hf01b2;
  localparam logic [19:0] ADDR_STOP = 20'hf01b4;
  localparam logic [19:0] ADDR_CLK_SEL = 20'hf01b6;
  localparam logic [19:0] ADDR_ROUTE = 20'hf01b8;

  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] CLK_SEL_RESET = 16'h0000;
  localparam logic [7:0] RUN_RESET = 8'h00;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [15:0] RDATA_IDLE = 16'h0000;

  // clock select fields
  localparam int PRS0_LSB = 0;
  localparam int PRS1_LSB = 4;
  localparam int PRS2_LSB = 8;
  localparam int PRS3_LSB = 12;
  localparam logic [15:0] CLK_SEL_WMASK = 16'h33ff;

  // mode register fields
  localparam int CHOICE_HI = 15;
  localparam int CHOICE_LO = 14;
  localparam int COUNT_SRC_BIT = 12;
  localparam int LEAD_BIT = 11;
  localparam int EDGE_LSB = 6;
  localparam logic [15:0] MODE_ZERO_WMASK = 16'hdfcf;
  localparam logic [15:0] BIT11_WMASK = 16'hf7ff;

  // channel groups
  localparam logic [7:0] WIDE_CHOICE_CH = 8'h0a;
  localparam logic [7:0] FIXED_BIT11_CH = 8'ha1;
  localparam logic [7:0] ROUTED_CH = 8'he3;

  // nibble i = log2 ratio for two-bit code i
  localparam logic [15:0] CK2_SHIFTS_DEF = 16'h6421;
  localparam logic [15:0] CK3_SHIFTS_DEF = 16'h6421;

  typedef enum logic [1:0] {
    SEL_CK0 = 2'b00,
    SEL_CK2 = 2'b01,
    SEL_CK1 = 2'b10,
    SEL_CK3 = 2'b11
  } tcs_op_sel_e;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_BOTH_ALT = 2'b11
  } tcs_edge_e;

  // power-of-two divider tap
  function automatic logic tick_at(logic [15:0] cnt, logic [3:0] shift);
    logic [15:0] mask;
    mask = (16'h0001 << shift) - 16'h0001;
    return (cnt & mask) == mask;
  endfunction : tick_at

  function automatic logic [3:0] shift_of(logic [15:0] tbl, logic [1:0] code);
    return tbl[{code, 2'b00} +: 4];
  endfunction : shift_of
endpackage : tcs_pkg
`default_nettype wire

// ===== verilog/tcs_edge_detect.sv
// timer clock select: valid edge detector of one channel input
// assumes level_i already synchronised to core_clk_i
`timescale 1ns/1ns
`default_nettype none
module tcs_edge_detect (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic op_tick_i,
  input wire logic level_i,
  input wire tcs_pkg::tcs_edge_e edge_choice_i,
  output logic edge_o
);
  import tcs_pkg::*;

  logic level_q;
  logic level_d;

  // input sampled only on the operation clock
  always_comb begin
    level_d = op_tick_i ? level_i : level_q;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end

  always_comb begin
    case (edge_choice_i)
      EDGE_FALL: edge_o = op_tick_i & level_q & ~level_i;
      EDGE_RISE: edge_o = op_tick_i & ~level_q & level_i;
      EDGE_BOTH: edge_o = op_tick_i & (level_q ^ level_i);
      default: edge_o = op_tick_i & (level_q ^ level_i);
    endcase
  end
endmodule : tcs_edge_detect
`default_nettype wire

// ===== verilog/tcs_clock_select.sv
// timer clock select: shared prescalers, per-channel clock choice,
// count clock enables and the register port that programs them
// assumes one clock, synchronous active-low reset, pins asynchronous
//
// How it works
// - clock zero from select bits 3:0
// - clock one from select bits 7:4
// - clock two from select bits 9:8
// - clock three from select bits 13:12
// - clocks two, three only for channels 1, 3
// - clock select written as one 16-bit word
// - reset clears clock select to zero
// - mode bits 15:14 pick channel operation clock
// - edge detector runs on operation clock
// - source bit picks operation clock or pin edges
// - routed channels count the selected input
// - bit 11 fixed zero on channels 0,5,7
// - per-channel running flag, readable
`timescale 1ns/1ns
`default_nettype none
module tcs_clock_select #(
  parameter logic [15:0] CK2_SHIFTS = tcs_pkg::CK2_SHIFTS_DEF,
  parameter logic [15:0] CK3_SHIFTS = tcs_pkg::CK3_SHIFTS_DEF
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [tcs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [tcs_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [tcs_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [tcs_pkg::NUM_CH-1:0] timer_input_pin_i,
  input wire logic [tcs_pkg::NUM_CH-1:0] alt_input_i,
  output logic [3:0] common_op_clock_o,
  output logic [tcs_pkg::NUM_CH-1:0] op_clk_tick_o,
  output logic [tcs_pkg::NUM_CH-1:0] channel_count_clock_o,
  output logic [tcs_pkg::NUM_CH-1:0] channel_running_flag_o
);
  import tcs_pkg::*;

  // mode slot decode: {hit, index}
  function automatic logic [3:0] mode_slot(logic [19:0] a);
    logic [19:0] off;
    off = a - ADDR_MODE_BASE;
    return {(a >= ADDR_MODE_BASE) && (a <= ADDR_MODE_LAST) && !a[0], off[3:1]};
  endfunction : mode_slot

  function automatic logic [15:0] mode_wmask(int ch);
    return FIXED_BIT11_CH[ch] ? (MODE_ZERO_WMASK & BIT11_WMASK) : MODE_ZERO_WMASK;
  endfunction : mode_wmask

  // ---------------- registers ----------------
  logic [15:0] mode_q [NUM_CH];
  logic [15:0] mode_d [NUM_CH];
  logic [15:0] clk_sel_q;
  logic [15:0] clk_sel_d;
  logic [7:0] route_q;
  logic [7:0] route_d;
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [3:0] wslot;
  logic [3:0] rslot;

  always_comb begin
    wslot = mode_slot(reg_addr_i);
    rslot = mode_slot(reg_addr_i);
    clk_sel_d = clk_sel_q;
    route_d = route_q;
    run_d = run_q;
    for (int n = 0; n < NUM_CH; n++) begin
      mode_d[n] = mode_q[n];
    end
    if (reg_wr_i) begin
      if (wslot[3]) begin
        // bit 11 stays zero where fixed, reserved bits stay zero
        mode_d[wslot[2:0]] = reg_wdata_i & mode_wmask(int'(wslot[2:0]));
      end
      if (reg_addr_i == ADDR_CLK_SEL) begin
        clk_sel_d = reg_wdata_i & CLK_SEL_WMASK;
      end
      if (reg_addr_i == ADDR_ROUTE) begin
        route_d = reg_wdata_i[7:0] & ROUTED_CH;
      end
      if (reg_addr_i == ADDR_START) begin
        run_d = run_q | reg_wdata_i[7:0];
      end
      if (reg_addr_i == ADDR_STOP) begin
        run_d = run_q & ~reg_wdata_i[7:0];
      end
    end
    rdata_d = RDATA_IDLE;
    if (reg_rd_i) begin
      if (rslot[3]) begin
        rdata_d = mode_q[rslot[2:0]];
      end else begin
        case (reg_addr_i)
          ADDR_CLK_SEL: rdata_d = clk_sel_q;
          ADDR_RUN_STATUS: rdata_d = {8'h00, run_q};
          ADDR_ROUTE: rdata_d = {8'h00, route_q};
          default: rdata_d = RDATA_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      clk_sel_q <= CLK_SEL_RESET;
      route_q <= ROUTE_RESET;
      run_q <= RUN_RESET;
      rdata_q <= RDATA_IDLE;
      for (int n = 0; n < NUM_CH; n++) begin
        mode_q[n] <= MODE_RESET;
      end
    end else begin
      clk_sel_q <= clk_sel_d;
      route_q <= route_d;
      run_q <= run_d;
      rdata_q <= rdata_d;
      for (int n = 0; n < NUM_CH; n++) begin
        mode_q[n] <= mode_d[n];
      end
    end
  end

  assign reg_rdata_o = rdata_q;
  assign channel_running_flag_o = run_q;

  // ---------------- shared prescalers ----------------
  logic [PRESC_W-1:0] cnt_q;
  logic [PRESC_W-1:0] cnt_d;
  logic [3:0] ck_tick_q;
  logic [3:0] ck_tick_d;

  always_comb begin
    cnt_d = cnt_q + 16'h0001;
    ck_tick_d[0] = tick_at(cnt_q, clk_sel_q[PRS0_LSB +: 4]);
    ck_tick_d[1] = tick_at(cnt_q, clk_sel_q[PRS1_LSB +: 4]);
    ck_tick_d[2] = tick_at(cnt_q, shift_of(CK2_SHIFTS, clk_sel_q[PRS2_LSB +: 2]));
    ck_tick_d[3] = tick_at(cnt_q, shift_of(CK3_SHIFTS, clk_sel_q[PRS3_LSB +: 2]));
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      ck_tick_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
      ck_tick_q <= ck_tick_d;
    end
  end

  assign common_op_clock_o = ck_tick_q;

  // ---------------- input synchronisers ----------------
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else begin
      sync1_q <= {alt_input_i, timer_input_pin_i};
      sync2_q <= sync1_q;
    end
  end

  // ---------------- per-channel clock choice ----------------
  logic [NUM_CH-1:0] op_tick;
  logic [NUM_CH-1:0] in_level;
  logic [NUM_CH-1:0] edge_hit;
  logic [NUM_CH-1:0] op_out_d;
  logic [NUM_CH-1:0] count_d;
  logic [NUM_CH-1:0] op_out_q;
  logic [NUM_CH-1:0] count_q;
  tcs_op_sel_e choice [NUM_CH];

  always_comb begin
    for (int n = 0; n < NUM_CH; n++) begin
      // narrow channels only see the high choice bit
      choice[n] = WIDE_CHOICE_CH[n] ? tcs_op_sel_e'(mode_q[n][CHOICE_HI:CHOICE_LO])
                                    : tcs_op_sel_e'({mode_q[n][CHOICE_HI], 1'b0});
      case (choice[n])
        SEL_CK0: op_tick[n] = ck_tick_q[0];
        SEL_CK2: op_tick[n] = ck_tick_q[2];
        SEL_CK1: op_tick[n] = ck_tick_q[1];
        SEL_CK3: op_tick[n] = ck_tick_q[3];
        default: op_tick[n] = ck_tick_q[0];
      endcase
      in_level[n] = (ROUTED_CH[n] && route_q[n]) ? sync2_q[NUM_CH + n] : sync2_q[n];
      op_out_d[n] = op_tick[n];
      // count clock: operation clock or valid input edge
      count_d[n] = run_q[n] & (mode_q[n][COUNT_SRC_BIT] ? edge_hit[n] : op_tick[n]);
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_edge
    tcs_edge_detect u_edge (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .op_tick_i(op_tick[g]),
      .level_i(in_level[g]),
      .edge_choice_i(tcs_edge_e'(mode_q[g][EDGE_LSB +: 2])),
      .edge_o(edge_hit[g])
    );
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      op_out_q <= '0;
      count_q <= '0;
    end else begin
      op_out_q <= op_out_d;
      count_q <= count_d;
    end
  end

  assign op_clk_tick_o = op_out_q;
  assign channel_count_clock_o = count_q;

  // ---------------- checks ----------------
  sequence s_start_ch2;
    reg_wr_i && reg_addr_i == ADDR_START && reg_wdata_i[2];
  endsequence

  sequence s_status_read;
    reg_rd_i && reg_addr_i == ADDR_RUN_STATUS;
  endsequence

  a_reset_clear: assert property (
    @(posedge core_clk_i) !rstn_i |=> clk_sel_q == CLK_SEL_RESET && mode_q[0] == MODE_RESET)
    else $error("clock select not cleared by reset");

  a_ck0_half_rate: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    clk_sel_q[3:0] == 4'h1 && $past(clk_sel_q[3:0]) == 4'h1 && ck_tick_q[0] |=> !ck_tick_q[0])
    else $error("clock zero ticks faster than divide by two");

  a_ck1_full_rate: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    rstn_i && clk_sel_q[7:4] == 4'h0 |=> ck_tick_q[1])
    else $error("clock one missing at divide by one");

  a_ck2_spacing: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    CK2_SHIFTS[3:0] != 4'h0 && clk_sel_q[9:8] == 2'b00 && ck_tick_q[2] |=> !ck_tick_q[2])
    else $error("clock two ticks back to back");

  a_ck3_spacing: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    CK3_SHIFTS[3:0] != 4'h0 && clk_sel_q[13:12] == 2'b00 && ck_tick_q[3] |=> !ck_tick_q[3])
    else $error("clock three ticks back to back");

  a_narrow_choice: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    1'b1 |=> op_clk_tick_o[0] == ($past(mode_q[0][CHOICE_HI]) ? $past(ck_tick_q[1])
                                                               : $past(ck_tick_q[0])))
    else $error("channel zero reached clock two or three");

  a_wide_choice: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    mode_q[1][CHOICE_HI:CHOICE_LO] == 2'b01 |=> op_clk_tick_o[1] == $past(ck_tick_q[2]))
    else $error("channel one choice 01 not on clock two");

  a_clk_sel_write: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    reg_wr_i && reg_addr_i == ADDR_CLK_SEL |=> clk_sel_q == ($past(reg_wdata_i) & CLK_SEL_WMASK))
    else $error("clock select word not stored");

  a_fixed_bit11: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    !mode_q[0][LEAD_BIT] && !mode_q[5][LEAD_BIT] && !mode_q[7][LEAD_BIT])
    else $error("fixed bit 11 became one");

  a_count_source: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    run_q[2] && !mode_q[2][COUNT_SRC_BIT] |=> channel_count_clock_o[2] == $past(op_tick[2]))
    else $error("count clock does not follow operation clock");

  a_start_status: assert property (
    @(posedge core_clk_i) disable iff (!rstn_i)
    s_start_ch2 ##1 s_status_read |=> reg_rdata_o[2])
    else $error("running flag not set after start");
endmodule : tcs_clock_select
`default_nettype wire

// ===== dv/tcs_clock_select_bench.sv
// timer clock select bench: register port, common clocks, channel count clocks
// assumes default prescaler tables, 250 MHz core clock, pins driven by the bench
`timescale 1ns/1ns
`default_nettype none
module tcs_clock_select_bench;
  import tcs_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [NUM_CH-1:0] timer_input_pin_i = '0;
  logic [NUM_CH-1:0] alt_input_i = '0;
  logic [3:0] common_op_clock_o;
  logic [NUM_CH-1:0] op_clk_tick_o;
  logic [NUM_CH-1:0] channel_count_clock_o;
  logic [NUM_CH-1:0] channel_running_flag_o;
  wire logic [23:0] mon;
  int errors = 0;
  int samples_checked = 0;

  always #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
  // common 0..3, op ticks 8..15, count clocks 16..23
  assign mon = {channel_count_clock_o, op_clk_tick_o, 4'h0, common_op_clock_o};

  tcs_clock_select i_dut (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .timer_input_pin_i(timer_input_pin_i),
    .alt_input_i(alt_input_i),
    .common_op_clock_o(common_op_clock_o),
    .op_clk_tick_o(op_clk_tick_o),
    .channel_count_clock_o(channel_count_clock_o),
    .channel_running_flag_o(channel_running_flag_o)
  );

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic check_value(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check_value

  task automatic reg_write(input logic [19:0] addr, input logic [15:0] data);
    @(posedge core_clk_i);
    reg_addr_i <= addr;
    reg_wdata_i <= data;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  task automatic expect_reg(input logic [19:0] addr, input logic [15:0] exp, input string name);
    @(posedge core_clk_i);
    reg_addr_i <= addr;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check_value(name, reg_rdata_o, exp);
  endtask : expect_reg

  // cycles between two later pulses, skipping the one straddling a change
  task automatic period_of(input int idx, output int cycles);
    for (int k = 0; k < 3; k++) begin
      cycles = 0;
      do begin
        @(posedge core_clk_i);
        #1;
        cycles++;
      end while (mon[idx] !== 1'b1 && cycles < 300);
    end
  endtask : period_of

  task automatic count_pulses(input int idx, input int len, input int exp, input string name);
    int n;
    n = 0;
    repeat (len) begin
      @(posedge core_clk_i);
      #1;
      if (mon[idx] === 1'b1) n++;
    end
    check_value(name, 16'(n), 16'(exp));
  endtask : count_pulses

  task automatic test_regs();
    expect_reg(ADDR_CLK_SEL, 16'h0000, "clk_sel reset");
    for (int n = 0; n < 8; n++) begin
      expect_reg(ADDR_MODE_BASE + 20'(2 * n), 16'h0000, "mode reset");
      reg_write(ADDR_MODE_BASE + 20'(2 * n), 16'hffff);
      expect_reg(ADDR_MODE_BASE + 20'(2 * n),
                 (n == 0 || n == 5 || n == 7) ? 16'hd7cf : 16'hdfcf, "mode mask");
      reg_write(ADDR_MODE_BASE + 20'(2 * n), 16'h0000);
    end
    reg_write(ADDR_CLK_SEL, 16'hffff);
    expect_reg(ADDR_CLK_SEL, 16'h33ff, "clk_sel word");
    expect_reg(20'hf01fe, 16'h0000, "unmapped read");
    $display("test regs done");
  endtask : test_regs

  task automatic test_clocks();
    int per;
    int exp_p[4] = '{8, 4, 64, 16};
    // all channels stopped here, so any field may change
    reg_write(ADDR_CLK_SEL, 16'h2323);
    for (int i = 0; i < 4; i++) begin
      period_of(i, per);
      check_value("common clock period", 16'(per), 16'(exp_p[i]));
    end
    reg_write(ADDR_CLK_SEL, 16'h0001);
    period_of(0, per);
    check_value("clock zero divide by two", 16'(per), 16'h0002);
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    expect_reg(ADDR_CLK_SEL, 16'h0000, "clk_sel after reset");
    $display("test clocks done");
  endtask : test_clocks

  task automatic test_choice();
    int per;
    int e1[4] = '{8, 64, 4, 16};
    int e2[4] = '{8, 8, 4, 4};
    reg_write(ADDR_CLK_SEL, 16'h2323);
    for (int s = 0; s < 4; s++) begin
      reg_write(ADDR_MODE_BASE + 20'h2, {2'(s), 14'h0000});
      reg_write(ADDR_MODE_BASE + 20'h4, {2'(s), 14'h0000});
      period_of(9, per);
      check_value("ch1 op period", 16'(per), 16'(e1[s]));
      period_of(10, per);
      check_value("ch2 op period", 16'(per), 16'(e2[s]));
    end
    $display("test choice done");
  endtask : test_choice

  task automatic test_count();
    reg_write(ADDR_MODE_BASE + 20'h2, 16'h0000);
    count_pulses(17, 64, 0, "ch1 stopped count");
    reg_write(ADDR_START, 16'h0002);
    expect_reg(ADDR_RUN_STATUS, 16'h0002, "run status");
    count_pulses(17, 64, 8, "ch1 op count");
    reg_write(ADDR_MODE_BASE + 20'h4, 16'h1040);
    reg_write(ADDR_START, 16'h0004);
    // status read straight after the start write, no idle cycle
    reg_addr_i <= ADDR_RUN_STATUS;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check_value("run status back to back", reg_rdata_o, 16'h0006);
    check_value("running flags", {8'h00, channel_running_flag_o}, 16'h0006);
    repeat (10) @(posedge core_clk_i);
    timer_input_pin_i[2] <= 1'b1;
    count_pulses(18, 30, 1, "ch2 rise count");
    timer_input_pin_i[2] <= 1'b0;
    count_pulses(18, 30, 0, "ch2 fall ignored");
    reg_write(ADDR_ROUTE, 16'h0001);
    reg_write(ADDR_MODE_BASE, 16'h1040);
    reg_write(ADDR_START, 16'h0001);
    repeat (10) @(posedge core_clk_i);
    timer_input_pin_i[0] <= 1'b1;
    count_pulses(16, 30, 0, "ch0 pin unrouted");
    alt_input_i[0] <= 1'b1;
    count_pulses(16, 30, 1, "ch0 routed count");
    reg_write(ADDR_STOP, 16'h00ff);
    expect_reg(ADDR_RUN_STATUS, 16'h0000, "all stopped");
    check_value("running flags stopped", {8'h00, channel_running_flag_o}, 16'h0000);
    count_pulses(17, 64, 0, "ch1 count after stop");
    $display("test count done");
  endtask : test_count

  initial begin
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    test_regs();
    test_clocks();
    test_choice();
    test_count();
    finish_test();
  end

  // tests need about 1100 cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule : tcs_clock_select_bench
`default_nettype wire
